// ==== core/adc_conv_pkg.sv ====
/*
 * Shared constants for the 8-bit successive-approximation converter control:
 * register map, field layout, reset values, timing counts and sequencer states.
 * Assumes a 125 MHz system clock.
 */
package adc_conv_pkg;

    // ------------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 8000;
    localparam int DIV_RATIO     = 4;
    localparam int CONV_TICKS    = 12;
    localparam int SAR_BITS      = 8;
    localparam int LOAD_TICKS    = CONV_TICKS - SAR_BITS;
    localparam int STAB_TIME_NS  = 1000;
    localparam int STAB_CYCLES   = (STAB_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // ------------------------------------------------------------------
    // Register map (indices; byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [7:0] RESULT_IDX = 8'h0a;
    localparam logic [7:0] CSR_IDX    = 8'h0b;

    localparam int DONE_BIT = 7;
    localparam int ON_BIT   = 5;
    localparam int CH_LSB   = 0;
    localparam int CH_W     = 4;

    localparam logic [7:0] CSR_RESET    = 8'h00;
    localparam logic [7:0] RESULT_RESET = 8'h00;

    // ------------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_STAB = 4'b0010,
        ST_LOAD = 4'b0100,
        ST_CONV = 4'b1000
    } seq_state_t;

    function automatic logic [7:0] reg_addr(input logic [7:0] idx);
        return {idx[5:0], 2'b00};
    endfunction : reg_addr

endpackage : adc_conv_pkg

// ==== core/adc_tick_div.sv ====
/*
 * Converter clock enable: one-cycle pulse every DIV system clocks.
 * Assumes i_restart realigns the phase so the first pulse lands DIV clocks later.
 */
`timescale 1ns/10ps
module adc_tick_div #(
    parameter int DIV = 4
) (
    // Clock and reset
    input  wire logic i_clock,
    input  wire logic i_rst,
    // Control
    input  wire logic i_restart,
    input  wire logic i_run,
    // Enable
    output logic      o_tick
);
    localparam int CW = (DIV > 2) ? $clog2(DIV) : 1;
    localparam logic [CW-1:0] LAST = CW'(DIV - 2);

    logic [CW-1:0] count;

    generate
        if (DIV < 2) begin : g_bad_div
            $error("adc_tick_div: DIV must be at least 2");
        end
    endgenerate

    always_ff @(posedge i_clock) begin
        if (i_rst || i_restart || !i_run) begin
            count  <= '0;
            o_tick <= 1'b0;
        end else begin
            count  <= (count == CW'(DIV - 1)) ? '0 : count + 1'b1;
            o_tick <= (count == LAST);
        end
    end

endmodule : adc_tick_div

// ==== core/adc_sar.sv ====
/*
 * Successive-approximation register: presents trial codes and resolves one
 * bit per step from the comparator decision, MSB first.
 * Assumes i_cmp is high when the held input is at or above the trial level.
 */
`timescale 1ns/10ps
module adc_sar #(
    parameter int W = 8
) (
    // Clock and reset
    input  wire logic         i_clock,
    input  wire logic         i_rst,
    // Sequencing
    input  wire logic         i_start,
    input  wire logic         i_step,
    input  wire logic         i_cmp,
    // Results
    output logic [W-1:0]      o_trial,
    output logic [W-1:0]      o_result,
    output logic              o_valid
);
    logic [W-1:0] mask;
    logic [W-1:0] code;

    generate
        if (W < 2) begin : g_bad_w
            $error("adc_sar: W must be at least 2");
        end
    endgenerate

    // Keep the trial bit when the input reaches it
    assign code = i_cmp ? o_trial : (o_trial & ~mask);

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_trial  <= '0;
            mask     <= '0;
            o_result <= '0;
            o_valid  <= 1'b0;
        end else begin
            o_valid <= 1'b0;
            if (i_start) begin
                o_trial <= {1'b1, {(W-1){1'b0}}};
                mask    <= {1'b1, {(W-1){1'b0}}};
            end else if (i_step && (mask != '0)) begin
                o_trial <= code | (mask >> 1);
                mask    <= mask >> 1;
                if (mask[0]) begin
                    o_result <= code;
                    o_valid  <= 1'b1;
                end
            end
        end
    end

endmodule : adc_sar

// ==== core/adc_conversion_control.sv ====
/*
 * Converter control: Avalon-MM register slave, load/compute sequencer,
 * comparator synchroniser, done flag and result register.
 * Assumes an external sample-hold, trial DAC and comparator; i_compare is
 * asynchronous, i_halt comes from logic on i_clock.
 */
// Implementation choices: the Avalon-MM register port and the register addresses.
// Functional notes
// - Each result is 8 bits, found by successive approximation on a held sample.
// - Sixteen inputs; the 4-bit channel field picks the converted one.
// - Input at or above high reference yields FFh, no overflow flag.
// - Input at or below low reference yields 00h.
// - Load phase, then 8 approximation cycles with the capacitor disconnected.
// - While on, load and compute phases repeat back to back.
// - A conversion lasts 12 converter clocks; converter clock is system clock over 4.
// - Setting converter_on starts the first conversion, then converts continuously.
// - Each finished conversion sets the done flag; no interrupt.
// - Result register holds until the next conversion finishes.
// - Control write with converter_on set aborts, clears done, restarts.
// - Wait mode leaves the converter running.
// - Halt disables the converter; a settling interval follows wake-up.
// - Clearing converter_on stops conversions and powers the converter down.
// - Control layout: done bit 7, on bit 5, channel 3:0; bits 6, 4 zero.
// - Reading the result or writing control clears the done flag.
// - Channel value n selects analog input n.
// - Result register is read-only and resets to zero.
`timescale 1ns/10ps
module adc_conversion_control
    import adc_conv_pkg::*;
#(
    parameter int STAB_COUNT = STAB_CYCLES
) (
    // Clock and reset
    input  wire logic        i_clock,
    input  wire logic        i_rst,
    // Avalon-MM slave
    input  wire logic [7:0]  i_address,
    input  wire logic        i_read,
    input  wire logic        i_write,
    input  wire logic [31:0] i_writedata,
    input  wire logic [3:0]  i_byteenable,
    output logic [31:0]      o_readdata,
    output logic             o_waitrequest,
    // Low-power control
    input  wire logic        i_halt,
    // Analog front end
    input  wire logic        i_compare,
    output logic [CH_W-1:0]  o_channel,
    output logic             o_sample,
    output logic [7:0]       o_trial_code,
    output logic             o_analog_on
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    seq_state_t         state;
    seq_state_t         next_state;
    logic [CH_W-1:0]    channel_select;
    logic               converter_on;
    logic               conv_done;
    logic [7:0]         result_register;
    logic [3:0]         tick_cnt;
    logic [15:0]        stab_cnt;
    logic               cmp_s1;
    logic               cmp_s2;
    logic               cmp_s3;
    logic               cmp_hold;
    logic               next_cmp;
    logic               tick;
    logic               taken;
    logic               csr_wr;
    logic               csr_wr_on;
    logic               res_rd;
    logic               restart;
    logic               load_end;
    logic               conv_end;
    logic               sar_start;
    logic               sar_step;
    logic [7:0]         sar_result;
    logic               sar_valid;
    logic [7:0]         csr_view;

    generate
        if (STAB_COUNT < 1 || STAB_COUNT > 65535) begin : g_bad_stab
            $error("adc_conversion_control: STAB_COUNT must be 1..65535");
        end
    endgenerate

    // ------------------------------------------------------------------
    // Avalon-MM slave: one wait cycle, then the request is taken
    // ------------------------------------------------------------------
    assign taken     = (i_read || i_write) && !o_waitrequest;
    assign csr_wr    = taken && i_write && i_byteenable[0]
                       && (i_address == reg_addr(CSR_IDX));
    assign csr_wr_on = csr_wr && i_writedata[ON_BIT];
    assign res_rd    = taken && i_read && (i_address == reg_addr(RESULT_IDX));
    assign csr_view  = {conv_done, 1'b0, converter_on, 1'b0, channel_select};

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_waitrequest <= 1'b1;
            o_readdata    <= 32'h0000_0000;
        end else if (o_waitrequest && (i_read || i_write)) begin
            o_waitrequest <= 1'b0;
            if (i_address == reg_addr(CSR_IDX)) begin
                o_readdata <= {24'h00_0000, csr_view};
            end else if (i_address == reg_addr(RESULT_IDX)) begin
                o_readdata <= {24'h00_0000, result_register};
            end else begin
                o_readdata <= 32'h0000_0000;
            end
        end else begin
            o_waitrequest <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Control fields
    // ------------------------------------------------------------------
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            channel_select <= CSR_RESET[CH_LSB +: CH_W];
            converter_on   <= CSR_RESET[ON_BIT];
        end else if (csr_wr) begin
            channel_select <= i_writedata[CH_LSB +: CH_W];
            converter_on   <= i_writedata[ON_BIT];
        end
    end

    assign o_channel = channel_select;

    // Done flag: a finishing conversion wins over a clearing access
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            conv_done <= CSR_RESET[DONE_BIT];
        end else if (sar_valid) begin
            conv_done <= 1'b1;
        end else if (res_rd || csr_wr) begin
            conv_done <= 1'b0;
        end
    end

    // Read-only result, replaced only when a conversion completes
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            result_register <= RESULT_RESET;
        end else if (sar_valid) begin
            result_register <= sar_result;
        end
    end

    // ------------------------------------------------------------------
    // Comparator synchroniser: a change counts once stages 2 and 3 agree
    // ------------------------------------------------------------------
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            cmp_s1   <= 1'b0;
            cmp_s2   <= 1'b0;
            cmp_s3   <= 1'b0;
            cmp_hold <= 1'b0;
        end else begin
            cmp_s1   <= i_compare;
            cmp_s2   <= cmp_s1;
            cmp_s3   <= cmp_s2;
            cmp_hold <= next_cmp;
        end
    end

    assign next_cmp = (cmp_s2 == cmp_s3) ? cmp_s3 : cmp_hold;

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    // Wait mode has no input here, so it cannot disturb conversions.
    assign load_end  = (state == ST_LOAD) && tick
                       && (tick_cnt == 4'(LOAD_TICKS - 1));
    assign conv_end  = (state == ST_CONV) && tick
                       && (tick_cnt == 4'(SAR_BITS - 1));
    assign restart   = !i_halt && (csr_wr_on
                       || ((state == ST_STAB) && (stab_cnt == 16'd1)));
    assign sar_start = load_end && !restart && !i_halt;
    assign sar_step  = (state == ST_CONV) && tick && !restart && !i_halt;

    always_comb begin
        next_state = state;
        if (i_halt) begin
            next_state = ST_IDLE;
        end else if (csr_wr && !i_writedata[ON_BIT]) begin
            next_state = ST_IDLE;
        end else if (restart) begin
            next_state = ST_LOAD;
        end else begin
            case (state)
                ST_IDLE: next_state = converter_on ? ST_STAB : ST_IDLE;
                ST_STAB: next_state = ST_STAB;
                ST_LOAD: next_state = load_end ? ST_CONV : ST_LOAD;
                ST_CONV: next_state = conv_end ? ST_LOAD : ST_CONV;
                default: next_state = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            state    <= ST_IDLE;
            o_sample <= 1'b0;
        end else begin
            state    <= next_state;
            o_sample <= (next_state == ST_LOAD);
        end
    end

    // Tick count within the current phase
    always_ff @(posedge i_clock) begin
        if (i_rst || restart || load_end || conv_end) begin
            tick_cnt <= 4'h0;
        end else if (tick) begin
            tick_cnt <= tick_cnt + 4'h1;
        end
    end

    // Settling interval after wake-up from halt
    always_ff @(posedge i_clock) begin
        if (i_rst || (state != ST_STAB)) begin
            stab_cnt <= 16'(STAB_COUNT);
        end else if (stab_cnt != 16'd1) begin
            stab_cnt <= stab_cnt - 16'd1;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_analog_on <= 1'b0;
        end else begin
            o_analog_on <= converter_on && !i_halt;
        end
    end

    // ------------------------------------------------------------------
    // Converter clock and approximation register
    // ------------------------------------------------------------------
    adc_tick_div #(
        .DIV        (DIV_RATIO)
    ) u_tick_div (
        .i_clock    (i_clock),
        .i_rst      (i_rst),
        .i_restart  (restart),
        .i_run      ((state == ST_LOAD) || (state == ST_CONV)),
        .o_tick     (tick)
    );

    // Comparator high on full scale keeps all bits; low clears them.
    adc_sar #(
        .W          (SAR_BITS)
    ) u_sar (
        .i_clock    (i_clock),
        .i_rst      (i_rst),
        .i_start    (sar_start),
        .i_step     (sar_step),
        .i_cmp      (next_cmp),
        .o_trial    (o_trial_code),
        .o_result   (sar_result),
        .o_valid    (sar_valid)
    );

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    logic [7:0] conv_age;

    always_ff @(posedge i_clock) begin
        if (i_rst || restart) begin
            conv_age <= 8'h00;
        end else if (sar_valid) begin
            conv_age <= 8'h01;
        end else if (conv_age != 8'hff) begin
            conv_age <= conv_age + 8'h01;
        end
    end

    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_rst);

    a_conv_length: assert property (sar_valid |-> conv_age == 8'd48)
        else $error("conversion did not take 48 clocks");
    a_done_set: assert property (sar_valid |=> conv_done)
        else $error("done flag not set after conversion");
    a_result_hold: assert property (!$stable(result_register) |-> $past(sar_valid))
        else $error("result changed without a finished conversion");
    a_done_clear: assert property ((res_rd && !sar_valid) |=> !conv_done)
        else $error("result read did not clear done");
    a_write_abort: assert property ((csr_wr_on && !i_halt && !sar_valid)
        |=> (state == ST_LOAD) && !conv_done && o_sample)
        else $error("control write did not restart conversion");
    a_off_stops: assert property ((csr_wr && !i_writedata[ON_BIT])
        |=> (state == ST_IDLE) ##1 (!o_analog_on && !sar_valid))
        else $error("converter kept running after switch-off");
    a_halt_idle: assert property (i_halt |=> state == ST_IDLE && !o_sample)
        else $error("converter active during halt");
    a_hold_open: assert property ((state == ST_CONV) |-> !o_sample
        && $past((state == ST_LOAD) || (state == ST_CONV)))
        else $error("capacitor connected during compute phase");
    a_csr_layout: assert property ((!o_waitrequest
        && i_address == reg_addr(CSR_IDX)) |-> o_readdata[31:8] == 24'h0
        && !o_readdata[6] && !o_readdata[4])
        else $error("reserved control bits read non-zero");
    a_reset_vals: assert property ($past(i_rst) |-> !converter_on && !conv_done
        && channel_select == 4'h0 && result_register == 8'h00)
        else $error("wrong state after reset");

    c_result: cover property (sar_valid ##48 sar_valid);
    c_abort: cover property ((state == ST_CONV) ##1 csr_wr_on);
    c_halt_wake: cover property (i_halt ##1 !i_halt [*2] ##1 (state == ST_STAB));
    c_read_done: cover property (conv_done ##1 res_rd);

endmodule : adc_conversion_control

// ==== tb/adc_front_end_model.sv ====
/*
 * Behavioural analog front end: sixteen input levels, a sample-hold and a comparator.
 * Assumes the converter drives channel, sample, trial code and power on i_clock.
 */
`timescale 1ns/10ps
module adc_front_end_model (
    // Clock
    input  wire logic             i_clock,
    // Converter side
    input  wire logic [3:0]       i_channel,
    input  wire logic             i_sample,
    input  wire logic [7:0]       i_trial,
    input  wire logic             i_power,
    // Input levels, one code per channel
    input  wire logic [15:0][7:0] i_levels,
    // Comparator decision
    output logic                  o_compare
);
    // ------------------------------------------------------------
    // Sample-hold
    // ------------------------------------------------------------
    logic [7:0] held = 8'h00;
    logic       flip = 1'b0;

    // Capacitor follows the selected input only while loading
    always_ff @(posedge i_clock) begin
        flip <= ~flip;
        if (i_power && i_sample) begin
            held <= i_levels[i_channel];
        end
    end

    // ------------------------------------------------------------
    // Comparator
    // ------------------------------------------------------------
    // Powered down the output carries no meaning, so it wanders
    assign o_compare = i_power ? (held >= i_trial) : flip;
endmodule : adc_front_end_model

// ==== tb/adc_conversion_control_tb.sv ====
/*
 * Self-checking bench for the converter control: register bus, sequencing, halt.
 * Assumes adc_front_end_model on the analog side and a 125 MHz clock.
 */
`timescale 1ns/10ps
`define CHK(act, exp) begin total_checks++; if ((act) !== (exp)) begin err_count++; \
    $display("[FAIL] t=%0t got %h exp %h", $time, (act), (exp)); end end
module adc_conversion_control_tb;
    import adc_conv_pkg::*;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    localparam logic [7:0] CSR_A = {CSR_IDX[5:0], 2'b00};
    localparam logic [7:0] RES_A = {RESULT_IDX[5:0], 2'b00};
    logic             i_clock      = 1'b0;
    logic             i_rst        = 1'b1;
    logic [7:0]       i_address    = 8'h00;
    logic             i_read       = 1'b0;
    logic             i_write      = 1'b0;
    logic [31:0]      i_writedata  = 32'h0;
    logic [3:0]       i_byteenable = 4'hf;
    logic             i_halt       = 1'b0;
    logic             i_compare;
    logic [31:0]      o_readdata;
    logic             o_waitrequest;
    logic [3:0]       o_channel;
    logic             o_sample;
    logic [7:0]       o_trial_code;
    logic             o_analog_on;
    logic [15:0][7:0] levels;
    logic [31:0]      exp_q[$];
    logic [31:0]      msk_q[$];
    logic [31:0]      mon_e;
    logic [31:0]      mon_m;
    logic [31:0]      rd;
    logic [7:0]       old_lvl;
    logic [3:0]       ch;
    int               err_count    = 0;
    int               total_checks = 0;
    int               seed         = 45278;

    always #4 i_clock = ~i_clock;

    adc_conversion_control #(.STAB_COUNT(4)) dut_u (
        .i_clock(i_clock), .i_rst(i_rst), .i_address(i_address), .i_read(i_read),
        .i_write(i_write), .i_writedata(i_writedata), .i_byteenable(i_byteenable),
        .o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .i_halt(i_halt),
        .i_compare(i_compare), .o_channel(o_channel), .o_sample(o_sample),
        .o_trial_code(o_trial_code), .o_analog_on(o_analog_on)
    );

    adc_front_end_model fe_u (
        .i_clock(i_clock), .i_channel(o_channel), .i_sample(o_sample),
        .i_trial(o_trial_code), .i_power(o_analog_on), .i_levels(levels),
        .o_compare(i_compare)
    );

    // ------------------------------------------------------------
    // Bus tasks
    // ------------------------------------------------------------
    function automatic logic [31:0] csr_val(input logic on, input logic [3:0] c);
        return {24'h0, 2'b00, on, 1'b0, c};
    endfunction : csr_val

    task automatic bus_wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] be);
        int n;
        n = 0;
        @(posedge i_clock);
        i_address    <= a;
        i_write      <= 1'b1;
        i_writedata  <= {24'h0, d};
        i_byteenable <= be;
        do begin @(posedge i_clock); n++; end while (o_waitrequest !== 1'b0 && n < 50);
        i_write <= 1'b0;
        if (n >= 50) err_count++;
    endtask : bus_wr

    task automatic bus_rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
                          output logic [31:0] d);
        int n;
        n = 0;
        @(posedge i_clock);
        exp_q.push_back(e);
        msk_q.push_back(m);
        i_address <= a;
        i_read    <= 1'b1;
        do begin @(posedge i_clock); n++; end while (o_waitrequest !== 1'b0 && n < 50);
        d = o_readdata;
        i_read <= 1'b0;
        if (n >= 50) err_count++;
    endtask : bus_rd

    // Poll until the done flag shows, checking the other fields on the way
    task automatic wait_done(input logic [3:0] c);
        logic [31:0] d;
        int          n;
        n = 0;
        d = 32'h0;
        while (d[7] !== 1'b1 && n < 60) begin
            bus_rd(CSR_A, csr_val(1'b1, c), 32'hffffff7f, d);
            n++;
        end
        if (n >= 60) begin
            err_count++;
            $display("[FAIL] t=%0t got %h exp %h", $time, d, 32'h80);
        end
    endtask : wait_done

    // Sample-high span and rise-to-rise span of one conversion
    task automatic measure_phase;
        int hi;
        int lo;
        hi = 0;
        lo = 0;
        // Start from a low span so a load phase already under way is not counted short
        while (o_sample !== 1'b0 && lo < 200) begin @(posedge i_clock); lo++; end
        while (o_sample !== 1'b1 && lo < 200) begin @(posedge i_clock); lo++; end
        while (o_sample === 1'b1 && hi < 200) begin @(posedge i_clock); hi++; end
        lo = 0;
        while (o_sample !== 1'b1 && lo < 200) begin @(posedge i_clock); lo++; end
        `CHK(hi, LOAD_TICKS * DIV_RATIO)
        `CHK(hi + lo, CONV_TICKS * DIV_RATIO)
    endtask : measure_phase

    task automatic conclude;
        if (err_count == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : conclude

    // ------------------------------------------------------------
    // Read monitor
    // ------------------------------------------------------------
    always @(posedge i_clock) begin
        if (i_read === 1'b1 && o_waitrequest === 1'b0) begin
            if (exp_q.size() == 0) begin
                err_count++;
            end else begin
                mon_e = exp_q.pop_front();
                mon_m = msk_q.pop_front();
                `CHK(o_readdata & mon_m, mon_e & mon_m)
            end
        end
    end

    initial begin
        repeat (20000) @(posedge i_clock);
        err_count++;
        conclude();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        for (int i = 0; i < 16; i++) levels[i] = 8'($random(seed));
        repeat (20) @(posedge i_clock);
        i_rst <= 1'b0;
        repeat (2) @(posedge i_clock);
        bus_rd(CSR_A, 32'h0, 32'hffffffff, rd);
        bus_rd(RES_A, 32'h0, 32'hffffffff, rd);
        bus_wr(RES_A, 8'ha5, 4'hf);
        bus_rd(RES_A, 32'h0, 32'hffffffff, rd);
        bus_rd(8'h30, 32'h0, 32'hffffffff, rd);
        // Channels with full-scale, zero and random levels
        for (int i = 0; i < 6; i++) begin
            ch = (i == 0) ? 4'hf : 4'($random(seed));
            levels[ch] = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($random(seed));
            bus_wr(CSR_A, csr_val(1'b1, ch), 4'hf);
            bus_rd(CSR_A, csr_val(1'b1, ch), 32'hffffffff, rd);
            wait_done(ch);
            bus_rd(RES_A, {24'h0, levels[ch]}, 32'hffffffff, rd);
            bus_rd(CSR_A, csr_val(1'b1, ch), 32'hffffffff, rd);
        end
        measure_phase();
        // Result holds until a fresh conversion of the new level ends
        wait_done(ch);
        old_lvl = levels[ch];
        levels[ch] = ~old_lvl;
        bus_rd(RES_A, {24'h0, old_lvl}, 32'hffffffff, rd);
        bus_wr(CSR_A, csr_val(1'b1, ch), 4'hf);
        wait_done(ch);
        bus_rd(RES_A, {24'h0, ~old_lvl}, 32'hffffffff, rd);
        // Write without the low byte lane is ignored
        bus_wr(CSR_A, 8'h00, 4'h0);
        bus_rd(CSR_A, csr_val(1'b1, ch), 32'hffffff7f, rd);
        // Halt stops the converter, release resumes it
        bus_wr(CSR_A, csr_val(1'b1, ch), 4'hf);
        i_halt <= 1'b1;
        repeat (3) @(posedge i_clock);
        `CHK(o_analog_on, 1'b0)
        repeat (60) @(posedge i_clock);
        `CHK(o_sample, 1'b0)
        bus_rd(CSR_A, csr_val(1'b1, ch), 32'hffffffff, rd);
        i_halt <= 1'b0;
        wait_done(ch);
        bus_rd(RES_A, {24'h0, levels[ch]}, 32'hffffffff, rd);
        // Switching off stops conversions
        bus_wr(CSR_A, csr_val(1'b0, ch), 4'hf);
        repeat (100) @(posedge i_clock);
        `CHK(o_analog_on, 1'b0)
        `CHK(o_sample, 1'b0)
        bus_rd(CSR_A, csr_val(1'b0, ch), 32'hffffffff, rd);
        repeat (2) @(posedge i_clock);
        conclude();
    end
endmodule : adc_conversion_control_tb
